// *** rtl/fsp_pkg.sv ***
// Package for the flash self-programming controller: register map, fields, codes, timing.
// Assumes a 32-bit APB slave port and a synchronous fast RC oscillator tick.
package fsp_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_OP_CONTROL = 12'h000;
	localparam logic [11:0] OFS_UNLOCK_KEY = 12'h004;
	localparam logic [11:0] OFS_TABLE_PAGE = 12'h008;
	localparam logic [11:0] OFS_TABLE_ADDR = 12'h00C;

	// Operation control fields
	localparam int unsigned BIT_START = 15;
	localparam int unsigned BIT_PROGRAM_ENABLE = 14;
	localparam int unsigned BIT_SEQ_ERROR = 13;
	localparam int unsigned BIT_ERASE_SELECT = 6;
	localparam int unsigned OPSEL_LSB = 0;
	localparam int unsigned OPSEL_W = 4;
	localparam int unsigned KEY_W = 8;
	localparam int unsigned TABLE_PAGE_W = 8;
	localparam int unsigned TABLE_ADDR_W = 16;
	localparam int unsigned FLASH_ADDR_W = 24;

	// Reset values
	localparam logic [3:0] OPSEL_RESET = 4'h0;
	localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
	localparam logic [15:0] TABLE_ADDR_RESET = 16'h0000;

	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// Operation select codes
	localparam logic [3:0] OPC_BULK = 4'hF;
	localparam logic [3:0] OPC_SEGMENT = 4'hD;
	localparam logic [3:0] OPC_WORD = 4'h3;
	localparam logic [3:0] OPC_PAGE = 4'h2;
	localparam logic [3:0] OPC_ROW = 4'h1;
	localparam logic [3:0] OPC_CFG = 4'h0;

	// Alignment masks in program address units (two per instruction)
	localparam logic [23:0] PAGE_ALIGN_MASK = 24'hFFFC00;
	localparam logic [23:0] ROW_ALIGN_MASK = 24'hFFFF80;
	localparam logic [23:0] WORD_ALIGN_MASK = 24'hFFFFFE;

	// Durations in fast RC oscillator cycles (nominal 7.37 MHz, trimmed)
	localparam int unsigned ROW_WRITE_OSC_CYCLES = 11064;
	localparam int unsigned WORD_WRITE_OSC_CYCLES = 400;
	localparam int unsigned PAGE_ERASE_OSC_CYCLES = 20000;
	localparam int unsigned BULK_ERASE_OSC_CYCLES = 40000;
	localparam int unsigned CFG_OSC_CYCLES = 400;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_BULK_ERASE = 3'b001,
		OP_SEGMENT_ERASE = 3'b010,
		OP_PAGE_ERASE = 3'b011,
		OP_CFG_ERASE = 3'b100,
		OP_WORD_PROG = 3'b101,
		OP_ROW_PROG = 3'b110,
		OP_CFG_PROG = 3'b111
	} fsp_op_type;

	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_GOT_FIRST = 2'b01,
		KEY_UNLOCKED = 2'b10
	} fsp_key_state_type;

	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_RUN = 1'b1
	} fsp_seq_state_type;

	// Command to the flash array
	typedef struct packed {
		logic active;
		fsp_op_type op;
		logic [23:0] addr;
	} fsp_flash_cmd_type;

	// Decoded operation select
	typedef struct packed {
		logic listed;
		fsp_op_type op;
	} fsp_decode_type;

endpackage

// *** rtl/fsp_flash_self_program_control.sv ***
// Flash self-programming controller: APB control/key registers, unlock check, op timer.
// Assumes sys_reset_i is any non-power-on reset and fast_rc_tick_i is a one-cycle pulse.
//
// Functional notes
// - Stall processor for whole erase/program operation
// - Start bit 15 begins operation, self-clears
// - Keys 0x55 then 0xAA precede start
// - Key register write-only, reads as zero
// - Operations only with program enable set
// - Bit 13 flags bad sequence or termination
// - Erase select chooses erase or program
// - Erase codes: bulk, segment, page, config
// - Program codes: word, row, config byte
// - Unlisted codes perform no memory operation
// - Control bits cleared only by power-on (a warm reset also clears the start bit here)
// - Duration counted in fast RC cycles
// - Pages and rows aligned to boundaries
// - Address is table page plus offset
`timescale 1ns/1ps
`default_nettype none

module fsp_flash_self_program_control #(
	parameter int unsigned ROW_CYCLES = fsp_pkg::ROW_WRITE_OSC_CYCLES,
	parameter int unsigned WORD_CYCLES = fsp_pkg::WORD_WRITE_OSC_CYCLES,
	parameter int unsigned PAGE_CYCLES = fsp_pkg::PAGE_ERASE_OSC_CYCLES,
	parameter int unsigned BULK_CYCLES = fsp_pkg::BULK_ERASE_OSC_CYCLES,
	parameter int unsigned CFG_CYCLES = fsp_pkg::CFG_OSC_CYCLES,
	parameter int unsigned CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic sys_reset_i,
	input wire logic fast_rc_tick_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic cpu_stall_o,
	output logic op_done_o,
	output fsp_pkg::fsp_flash_cmd_type flash_cmd_o
);

	// Elaboration checks: the counter must hold every duration
	if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
		$error("CNT_W out of range");
	end
	if (ROW_CYCLES < 1 || WORD_CYCLES < 1 || PAGE_CYCLES < 1 || BULK_CYCLES < 1
			|| CFG_CYCLES < 1) begin : g_bad_length
		$error("Operation durations must be at least one cycle");
	end
	if (ROW_CYCLES >= (1 << CNT_W) || WORD_CYCLES >= (1 << CNT_W)
			|| PAGE_CYCLES >= (1 << CNT_W) || BULK_CYCLES >= (1 << CNT_W)
			|| CFG_CYCLES >= (1 << CNT_W)) begin : g_too_long
		$error("Operation durations exceed CNT_W");
	end

	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == fsp_pkg::OFS_OP_CONTROL) || (a == fsp_pkg::OFS_UNLOCK_KEY)
			|| (a == fsp_pkg::OFS_TABLE_PAGE) || (a == fsp_pkg::OFS_TABLE_ADDR);
	endfunction

	function automatic fsp_pkg::fsp_decode_type op_decode(input logic erase,
			input logic [3:0] code);
		op_decode.listed = 1'b1;
		op_decode.op = fsp_pkg::OP_NONE;
		if (erase) begin
			case (code)
				fsp_pkg::OPC_BULK: op_decode.op = fsp_pkg::OP_BULK_ERASE;
				fsp_pkg::OPC_SEGMENT: op_decode.op = fsp_pkg::OP_SEGMENT_ERASE;
				fsp_pkg::OPC_PAGE: op_decode.op = fsp_pkg::OP_PAGE_ERASE;
				fsp_pkg::OPC_CFG: op_decode.op = fsp_pkg::OP_CFG_ERASE;
				fsp_pkg::OPC_WORD, fsp_pkg::OPC_ROW: op_decode.op = fsp_pkg::OP_NONE;
				default: op_decode.listed = 1'b0;
			endcase
		end else begin
			case (code)
				fsp_pkg::OPC_WORD: op_decode.op = fsp_pkg::OP_WORD_PROG;
				fsp_pkg::OPC_ROW: op_decode.op = fsp_pkg::OP_ROW_PROG;
				fsp_pkg::OPC_CFG: op_decode.op = fsp_pkg::OP_CFG_PROG;
				fsp_pkg::OPC_BULK, fsp_pkg::OPC_SEGMENT, fsp_pkg::OPC_PAGE: begin
					op_decode.op = fsp_pkg::OP_NONE;
				end
				default: op_decode.listed = 1'b0;
			endcase
		end
	endfunction

	function automatic logic [CNT_W-1:0] op_cycles(input fsp_pkg::fsp_op_type op);
		case (op)
			fsp_pkg::OP_ROW_PROG: op_cycles = CNT_W'(ROW_CYCLES);
			fsp_pkg::OP_WORD_PROG: op_cycles = CNT_W'(WORD_CYCLES);
			fsp_pkg::OP_PAGE_ERASE: op_cycles = CNT_W'(PAGE_CYCLES);
			fsp_pkg::OP_BULK_ERASE, fsp_pkg::OP_SEGMENT_ERASE: op_cycles = CNT_W'(BULK_CYCLES);
			default: op_cycles = CNT_W'(CFG_CYCLES);
		endcase
	endfunction

	function automatic logic [23:0] op_addr(input fsp_pkg::fsp_op_type op,
			input logic [23:0] a);
		case (op)
			fsp_pkg::OP_PAGE_ERASE: op_addr = a & fsp_pkg::PAGE_ALIGN_MASK;
			fsp_pkg::OP_ROW_PROG: op_addr = a & fsp_pkg::ROW_ALIGN_MASK;
			fsp_pkg::OP_WORD_PROG: op_addr = a & fsp_pkg::WORD_ALIGN_MASK;
			fsp_pkg::OP_BULK_ERASE, fsp_pkg::OP_SEGMENT_ERASE: op_addr = 24'h000000;
			default: op_addr = a;
		endcase
	endfunction

	// Bus slave state
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;

	// Control state, kept across warm resets except start_reg (cleared) and err_reg (set during a run)
	logic start_reg, start_next;
	logic enable_reg, enable_next;
	logic err_reg, err_next;
	logic erase_reg, erase_next;
	logic [3:0] opsel_reg, opsel_next;
	logic [7:0] tpage_reg, tpage_next;
	logic [15:0] taddr_reg, taddr_next;

	// Sequencer state
	fsp_pkg::fsp_key_state_type key_reg, key_next;
	fsp_pkg::fsp_seq_state_type seq_reg, seq_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic stall_reg, stall_next;
	logic done_reg, done_next;
	fsp_pkg::fsp_flash_cmd_type cmd_reg, cmd_next;

	logic bus_access;
	logic bus_write;
	logic [23:0] target_addr;
	fsp_pkg::fsp_decode_type dec;

	// Zero-wait would need combinational pready; one wait state keeps outputs registered
	assign bus_access = psel_i && penable_i && pready_reg;
	assign bus_write = bus_access && pwrite_i;
	assign target_addr = {tpage_reg, taddr_reg};
	assign dec = op_decode(pwdata_i[fsp_pkg::BIT_ERASE_SELECT],
		pwdata_i[fsp_pkg::OPSEL_LSB +: fsp_pkg::OPSEL_W]);

	always_comb begin
		pready_next = psel_i && penable_i && !pready_reg;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		if (psel_i && penable_i && !pready_reg) begin
			pslverr_next = !addr_mapped(paddr_i);
			prdata_next = 32'h00000000;
			case (paddr_i)
				fsp_pkg::OFS_OP_CONTROL: begin
					prdata_next[fsp_pkg::BIT_START] = start_reg;
					prdata_next[fsp_pkg::BIT_PROGRAM_ENABLE] = enable_reg;
					prdata_next[fsp_pkg::BIT_SEQ_ERROR] = err_reg;
					prdata_next[fsp_pkg::BIT_ERASE_SELECT] = erase_reg;
					prdata_next[fsp_pkg::OPSEL_LSB +: fsp_pkg::OPSEL_W] = opsel_reg;
				end
				fsp_pkg::OFS_TABLE_PAGE: prdata_next[fsp_pkg::TABLE_PAGE_W-1:0] = tpage_reg;
				fsp_pkg::OFS_TABLE_ADDR: prdata_next[fsp_pkg::TABLE_ADDR_W-1:0] = taddr_reg;
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	always_comb begin
		start_next = start_reg;
		enable_next = enable_reg;
		err_next = err_reg;
		erase_next = erase_reg;
		opsel_next = opsel_reg;
		tpage_next = tpage_reg;
		taddr_next = taddr_reg;
		key_next = key_reg;
		seq_next = seq_reg;
		cnt_next = cnt_reg;
		stall_next = stall_reg;
		done_next = 1'b0;
		cmd_next = cmd_reg;
		if (bus_write && seq_reg == fsp_pkg::SEQ_IDLE) begin
			case (paddr_i)
				fsp_pkg::OFS_UNLOCK_KEY: begin
					if (pwdata_i[fsp_pkg::KEY_W-1:0] == fsp_pkg::KEY_FIRST) begin
						key_next = fsp_pkg::KEY_GOT_FIRST;
					end else if (pwdata_i[fsp_pkg::KEY_W-1:0] == fsp_pkg::KEY_SECOND
							&& key_reg == fsp_pkg::KEY_GOT_FIRST) begin
						key_next = fsp_pkg::KEY_UNLOCKED;
					end else begin
						key_next = fsp_pkg::KEY_IDLE;
					end
				end
				fsp_pkg::OFS_OP_CONTROL: begin
					key_next = fsp_pkg::KEY_IDLE;
					enable_next = pwdata_i[fsp_pkg::BIT_PROGRAM_ENABLE];
					err_next = pwdata_i[fsp_pkg::BIT_SEQ_ERROR];
					erase_next = pwdata_i[fsp_pkg::BIT_ERASE_SELECT];
					opsel_next = pwdata_i[fsp_pkg::OPSEL_LSB +: fsp_pkg::OPSEL_W];
					if (pwdata_i[fsp_pkg::BIT_START]) begin
						if (key_reg != fsp_pkg::KEY_UNLOCKED
								|| !pwdata_i[fsp_pkg::BIT_PROGRAM_ENABLE] || !dec.listed) begin
							err_next = 1'b1;
						end else if (dec.op == fsp_pkg::OP_NONE) begin
							err_next = 1'b0;
						end else begin
							err_next = 1'b0;
							start_next = 1'b1;
							seq_next = fsp_pkg::SEQ_RUN;
							stall_next = 1'b1;
							cnt_next = op_cycles(dec.op);
							cmd_next.active = 1'b1;
							cmd_next.op = dec.op;
							cmd_next.addr = op_addr(dec.op, target_addr);
						end
					end
				end
				fsp_pkg::OFS_TABLE_PAGE: begin
					key_next = fsp_pkg::KEY_IDLE;
					tpage_next = pwdata_i[fsp_pkg::TABLE_PAGE_W-1:0];
				end
				default: begin
					key_next = fsp_pkg::KEY_IDLE;
					if (paddr_i == fsp_pkg::OFS_TABLE_ADDR) begin
						taddr_next = pwdata_i[fsp_pkg::TABLE_ADDR_W-1:0];
					end
				end
			endcase
		end
		case (seq_reg)
			fsp_pkg::SEQ_RUN: begin
				if (fast_rc_tick_i) begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
				if (fast_rc_tick_i && cnt_reg == CNT_W'(1)) begin
					seq_next = fsp_pkg::SEQ_IDLE;
					start_next = 1'b0;
					stall_next = 1'b0;
					done_next = 1'b1;
					cmd_next.active = 1'b0;
					cmd_next.op = fsp_pkg::OP_NONE;
				end
			end
			// Idle keeps whatever the start write decided above
			default: ;
		endcase
		// A warm reset ends a running operation as a termination
		if (sys_reset_i) begin
			key_next = fsp_pkg::KEY_IDLE;
			if (seq_reg == fsp_pkg::SEQ_RUN) begin
				err_next = 1'b1;
				done_next = 1'b0;
			end
			seq_next = fsp_pkg::SEQ_IDLE;
			start_next = 1'b0;
			stall_next = 1'b0;
			cmd_next.active = 1'b0;
			cmd_next.op = fsp_pkg::OP_NONE;
		end
	end

	// Only the power-on reset clears the control bits other than start_reg; sys_reset_i is handled above
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			start_reg <= 1'b0;
			enable_reg <= 1'b0;
			err_reg <= 1'b0;
			erase_reg <= 1'b0;
			opsel_reg <= fsp_pkg::OPSEL_RESET;
			tpage_reg <= fsp_pkg::TABLE_PAGE_RESET;
			taddr_reg <= fsp_pkg::TABLE_ADDR_RESET;
			key_reg <= fsp_pkg::KEY_IDLE;
			seq_reg <= fsp_pkg::SEQ_IDLE;
			cnt_reg <= '0;
			stall_reg <= 1'b0;
			done_reg <= 1'b0;
			cmd_reg <= '0;
		end else if (ce_i) begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			start_reg <= start_next;
			enable_reg <= enable_next;
			err_reg <= err_next;
			erase_reg <= erase_next;
			opsel_reg <= opsel_next;
			tpage_reg <= tpage_next;
			taddr_reg <= taddr_next;
			key_reg <= key_next;
			seq_reg <= seq_next;
			cnt_reg <= cnt_next;
			stall_reg <= stall_next;
			done_reg <= done_next;
			cmd_reg <= cmd_next;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign cpu_stall_o = stall_reg;
	assign op_done_o = done_reg;
	assign flash_cmd_o = cmd_reg;

endmodule // fsp_flash_self_program_control

`default_nettype wire

// *** verification/fsp_flash_model.sv ***
// Fast RC oscillator model: tick pulses from the flash array side.
// Assumes one clock; slow_i stretches the tick period to three cycles.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	output logic tick_o
);
	logic [1:0] div_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
			tick_o <= !slow_i || div_reg == 2'h2;
		end
	end
endmodule // fsp_flash_model
`default_nettype wire

// *** verification/fsp_asserts.sv ***
// Checker for the flash self-programming controller ports.
// Assumes ce_i drops only while no APB transfer is in flight.
`timescale 1ns/1ps
`default_nettype none
module fsp_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic sys_reset_i,
	input wire logic fast_rc_tick_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic cpu_stall_o,
	input wire logic op_done_o,
	input wire fsp_pkg::fsp_flash_cmd_type flash_cmd_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	stall_cmd_a: assert property (cpu_stall_o == flash_cmd_o.active)
		else $error("stall and command disagree");
	one_wait_a: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
		else $error("no answer after one wait state");
	key_read_a: assert property (pready_o && !pwrite_i && paddr_i == fsp_pkg::OFS_UNLOCK_KEY
		|-> prdata_o == 32'h0) else $error("key register readable");
	start_cause_a: assert property ($rose(cpu_stall_o) |-> $past(pready_o && pwrite_i &&
		paddr_i == fsp_pkg::OFS_OP_CONTROL && pwdata_i[15] && pwdata_i[14]))
		else $error("stall without enabled start write");
	kind_a: assert property ($rose(cpu_stall_o) |-> flash_cmd_o.op != fsp_pkg::OP_NONE &&
		$past(pwdata_i[6]) == (flash_cmd_o.op inside {fsp_pkg::OP_BULK_ERASE,
		fsp_pkg::OP_SEGMENT_ERASE, fsp_pkg::OP_PAGE_ERASE, fsp_pkg::OP_CFG_ERASE}))
		else $error("erase select not followed");
	end_cause_a: assert property ($fell(cpu_stall_o) |-> $past(fast_rc_tick_i) ||
		$past(sys_reset_i)) else $error("operation ended without a tick");
	done_a: assert property (op_done_o |-> $fell(cpu_stall_o) && !$past(sys_reset_i))
		else $error("done pulse not at normal end");
	hold_a: assert property (cpu_stall_o && !fast_rc_tick_i && !sys_reset_i |=> cpu_stall_o)
		else $error("stall dropped early");
	align_a: assert property (flash_cmd_o.active |->
		(flash_cmd_o.op != fsp_pkg::OP_ROW_PROG || flash_cmd_o.addr[6:0] == 7'h00) &&
		(flash_cmd_o.op != fsp_pkg::OP_PAGE_ERASE || flash_cmd_o.addr[9:0] == 10'h000))
		else $error("target not aligned");
endmodule // fsp_asserts
bind fsp_flash_self_program_control fsp_asserts u_chk (.*);
`default_nettype wire

// *** verification/tb_flash_self_program_control.sv ***
// Testbench: APB master, read and command scoreboards, tick model.
// Short durations keep the run brief; ce_i drops once, mid-run, with the bus idle.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_control;
	logic clk_i = 1'b0, rst_n_i = 1'b0, sys_reset_i = 1'b0, slow = 1'b0, tick, ce_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic cpu_stall_o, op_done_o, act_q = 1'b0, lst;
	fsp_pkg::fsp_flash_cmd_type flash_cmd_o;
	fsp_pkg::fsp_op_type o;
	int errors = 0, check_count = 0, seed = 34206, ticks, d;
	logic [32:0] rq[$];
	logic [27:0] cq[$];
	logic [7:0] tp;
	logic [15:0] ta;
	logic [23:0] ad;
	fsp_flash_self_program_control #(.ROW_CYCLES(5), .WORD_CYCLES(3), .PAGE_CYCLES(7),
		.BULK_CYCLES(9), .CFG_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .sys_reset_i(sys_reset_i), .fast_rc_tick_i(tick), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.cpu_stall_o(cpu_stall_o), .op_done_o(op_done_o), .flash_cmd_o(flash_cmd_o));
	fsp_flash_model u_osc (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .tick_o(tick));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= dat;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [32:0] exp);
		rq.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask
	task keys(input logic [7:0] k1, input logic [7:0] k2);
		apb(1'b1, fsp_pkg::OFS_UNLOCK_KEY, {24'h0, k1});
		apb(1'b1, fsp_pkg::OFS_UNLOCK_KEY, {24'h0, k2});
	endtask
	// Scoreboards: oldest note is compared when the result appears
	always @(posedge clk_i) begin
		if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
			chk({pslverr_o, prdata_o}, rq.pop_front());
		if (flash_cmd_o.active && !act_q) chk(flash_cmd_o, cq.pop_front());
		act_q <= flash_cmd_o.active;
		if (cpu_stall_o && tick) ticks++;
	end
	initial begin
		#100000;
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(fsp_pkg::OFS_OP_CONTROL, 33'h0);
		rd(fsp_pkg::OFS_UNLOCK_KEY, 33'h0);
		rd(12'h010, 33'h100000000);
		for (int i = 0; i < 32; i++) begin
			tp = $random(seed);
			ta = $random(seed);
			slow <= i[0];
			lst = 1'b1;
			d = 0;
			o = fsp_pkg::OP_NONE;
			case (i[4:0])
				5'h1F: begin o = fsp_pkg::OP_BULK_ERASE; d = 9; end
				5'h1D: begin o = fsp_pkg::OP_SEGMENT_ERASE; d = 9; end
				5'h12: begin o = fsp_pkg::OP_PAGE_ERASE; d = 7; end
				5'h10: begin o = fsp_pkg::OP_CFG_ERASE; d = 4; end
				5'h03: begin o = fsp_pkg::OP_WORD_PROG; d = 3; end
				5'h01: begin o = fsp_pkg::OP_ROW_PROG; d = 5; end
				5'h00: begin o = fsp_pkg::OP_CFG_PROG; d = 4; end
				5'h13, 5'h11, 5'h0F, 5'h0D, 5'h02: ;
				default: lst = 1'b0;
			endcase
			ad = {tp, ta};
			case (o)
				fsp_pkg::OP_PAGE_ERASE: ad = ad & 24'hFFFC00;
				fsp_pkg::OP_ROW_PROG: ad = ad & 24'hFFFF80;
				fsp_pkg::OP_WORD_PROG: ad = ad & 24'hFFFFFE;
				fsp_pkg::OP_BULK_ERASE, fsp_pkg::OP_SEGMENT_ERASE: ad = 24'h000000;
				default: ;
			endcase
			apb(1'b1, fsp_pkg::OFS_TABLE_PAGE, {24'h0, tp});
			apb(1'b1, fsp_pkg::OFS_TABLE_ADDR, {16'h0, ta});
			if (o != fsp_pkg::OP_NONE) cq.push_back({1'b1, o, ad});
			ticks = 0;
			keys(8'h55, 8'hAA);
			apb(1'b1, fsp_pkg::OFS_OP_CONTROL, {16'h0, 9'h180, i[4], 2'h0, i[3:0]});
			if (o != fsp_pkg::OP_NONE) begin
				do @(negedge clk_i); while (op_done_o !== 1'b1);
				chk(ticks, d);
			end
			rd(fsp_pkg::OFS_OP_CONTROL, {19'h1, !lst, 6'h0, i[4], 2'h0, i[3:0]});
		end
		// Broken unlocks: wrong key, stray write, enable clear, reversed keys
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, fsp_pkg::OFS_UNLOCK_KEY, j == 3 ? 32'hAA : 32'h55);
			if (j == 1) apb(1'b1, fsp_pkg::OFS_TABLE_PAGE, 32'h0);
			apb(1'b1, fsp_pkg::OFS_UNLOCK_KEY, j == 0 ? 32'h56 : (j == 3 ? 32'h55 : 32'hAA));
			apb(1'b1, fsp_pkg::OFS_OP_CONTROL, j == 2 ? 32'h8001 : 32'hC001);
			rd(fsp_pkg::OFS_OP_CONTROL, j == 2 ? 33'h2001 : 33'h6001);
		end
		// Warm reset aborts a row write but keeps the control bits
		slow <= 1'b1;
		apb(1'b1, fsp_pkg::OFS_TABLE_PAGE, 32'h12);
		apb(1'b1, fsp_pkg::OFS_TABLE_ADDR, 32'h3456);
		cq.push_back({1'b1, fsp_pkg::OP_ROW_PROG, 24'h123400});
		keys(8'h55, 8'hAA);
		apb(1'b1, fsp_pkg::OFS_OP_CONTROL, 32'hC001);
		// A frozen enable must hold the run well past its normal length
		ce_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk({cpu_stall_o, op_done_o}, 33'h2);
		ce_i <= 1'b1;
		apb(1'b1, fsp_pkg::OFS_TABLE_PAGE, 32'h77);
		sys_reset_i <= 1'b1;
		@(posedge clk_i);
		sys_reset_i <= 1'b0;
		rd(fsp_pkg::OFS_OP_CONTROL, 33'h6001);
		rd(fsp_pkg::OFS_TABLE_PAGE, 33'h12);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(fsp_pkg::OFS_OP_CONTROL, 33'h0);
		tally_and_finish;
	end
endmodule // tb_flash_self_program_control
`default_nettype wire
